// file: common/flash_cmd_cfg.svh
// constants of the serial flash instruction front end
`ifndef FLASH_CMD_CFG_SVH
`define FLASH_CMD_CFG_SVH
`define CMD_LATCH_SET 8'h06
`define CMD_LATCH_CLEAR 8'h04
`define CMD_VOLATILE_SET 8'h50
`define CMD_STATUS_ONE_RD 8'h05
`define CMD_STATUS_TWO_RD 8'h35
`define CMD_STATUS_WR 8'h01
`define CMD_STATUS_TWO_WR 8'h31
`define CMD_READ 8'h03
`define CMD_FAST_READ 8'h0b
`define CMD_DUAL_READ 8'h3b
`define CMD_READ_PARAM 8'hc0
`define STATUS_ONE_WR_MASK 8'hfc
`define STATUS_TWO_WR_MASK 8'h43
`define STATUS_ONE_RESET 8'h00
`define STATUS_TWO_RESET 8'h00
`define LATCH_BIT 1
`define BUSY_BIT 0
`define READ_PARAM_RESET 2'h0
`define SPI_DUMMY_CLOCKS 4'h8
`define QUAD_DUMMY_LOW 4'h4
`define QUAD_DUMMY_MID 4'h6
`define QUAD_DUMMY_HIGH 4'h8
`define CLK_PERIOD_NS 5
`define STATUS_WRITE_TIME_NS 1000
`define STATUS_WRITE_CYCLES (`STATUS_WRITE_TIME_NS / `CLK_PERIOD_NS)
`endif

// file: common/flash_cmd_pkg.sv
// types of the serial flash instruction front end
package flash_cmd_pkg;
  typedef struct packed {
    logic csn;
    logic sck;
    logic [3:0] lanes;
  } link_in_s;
  typedef struct packed {
    logic [3:0] lanes;
    logic [3:0] oe;
  } link_out_s;
  typedef enum logic [2:0] {
    PH_CMD = 3'b000,
    PH_ADDR = 3'b001,
    PH_DUMMY = 3'b010,
    PH_DATA = 3'b011,
    PH_WDATA = 3'b100,
    PH_DONE = 3'b101,
    PH_IGNORE = 3'b110
  } phase_e;
endpackage

// file: design/serial_flash_cmd.sv
// serial flash instruction front end: latch, status and read instructions
// Functional notes
// - quad data: high nibble first, lane3 gets bit7
// - 06h then chip select high sets latch
// - status writes act only while latch is set or 50h armed
// - 04h then chip select high clears latch
// - latch clears at reset and write completion
// - 50h makes next status write volatile
// - 05h/35h return status, even while busy
// - status shifts out MSB first, repeating
// - 01h writes only protection, lock, complement, quad
// - status write needs exactly 8 bits, or 16 for 01h
// - one byte write clears complement, quad, lock b
// - busy high through self-timed write cycle
// - latch clears when busy asserts
// - 31h writes three status two bits
// - 03h: 24-bit address, incrementing MSB-first data
// - 03h/0Bh/3Bh reads while busy are ignored
// - 0Bh: address, dummy clocks, then data
// - quad mode dummy 4/6/8 from C0h param
// - quad dummy count defaults to 4
// - 3Bh outside quad mode: eight dummy clocks, two-lane data
// - dual: odd bits lane one, even lane zero
`timescale 1ns/1ps
`include "flash_cmd_cfg.svh"
module serial_flash_cmd import flash_cmd_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // link pins
  input wire link_in_s linkIn,
  output link_out_s linkOut,
  // configuration
  input wire logic fourLaneCommandMode,
  // array preload
  input wire logic memWrEn,
  input wire logic [7:0] memWrAddr,
  input wire logic [7:0] memWrData,
  // status view
  output logic [7:0] statusOne,
  output logic [7:0] statusTwo,
  output logic busyOut
);
  link_in_s linkS1;
  link_in_s linkS2;
  logic csnS3, sckS3;
  logic sckRise, sckFall, csnRise;
  logic [7:0] memArray [0:255];
  phase_e phaseReg;
  logic [7:0] cmdReg, inSr, outSr, statusTwoReg;
  logic [3:0] bitCnt, dummyCnt, outLeft;
  logic [23:0] addrReg;
  logic [1:0] addrBytes, readParam;
  logic [4:0] wrBits;
  logic [15:0] wrData, busyTimer;
  logic [5:0] statusOneBits;
  logic latchReg, volatileArm, busyReg;
  logic [7:0] inNext, srcByte, statusLive, wrFirst;
  logic [3:0] laneW, cntNext, dummyTarget, outW;
  logic byteDone, isStatusRd, writeOk, wrLenOk, nvAccept;

  // two-flop synchronisers and edge detect
  always_ff @(posedge clk) begin
    if (!rstn) begin
      linkS1 <= '{csn: 1'b1, sck: 1'b0, lanes: 4'h0};
      linkS2 <= '{csn: 1'b1, sck: 1'b0, lanes: 4'h0};
      csnS3 <= 1'b1;
      sckS3 <= 1'b0;
    end else if (ce) begin
      linkS1 <= linkIn;
      linkS2 <= linkS1;
      csnS3 <= linkS2.csn;
      sckS3 <= linkS2.sck;
    end
  end
  assign sckRise = ce && !linkS2.csn && linkS2.sck && !sckS3;
  assign sckFall = ce && !linkS2.csn && !linkS2.sck && sckS3;
  assign csnRise = ce && linkS2.csn && !csnS3;

  // decode helpers
  always_comb begin
    laneW = fourLaneCommandMode ? 4'h4 : 4'h1;
    inNext = fourLaneCommandMode ? {inSr[3:0], linkS2.lanes} : {inSr[6:0], linkS2.lanes[0]};
    cntNext = bitCnt + laneW;
    byteDone = cntNext == 4'h8;
    dummyTarget = `SPI_DUMMY_CLOCKS;
    if (fourLaneCommandMode) begin
      case (readParam)
        2'h0: dummyTarget = `QUAD_DUMMY_LOW;
        2'h1: dummyTarget = `QUAD_DUMMY_MID;
        default: dummyTarget = `QUAD_DUMMY_HIGH;
      endcase
    end
    outW = (cmdReg == `CMD_DUAL_READ) ? 4'h2 : laneW;
    isStatusRd = cmdReg == `CMD_STATUS_ONE_RD || cmdReg == `CMD_STATUS_TWO_RD;
    statusLive = (cmdReg == `CMD_STATUS_TWO_RD) ? statusTwoReg
      : {statusOneBits, latchReg, busyReg};
    if (outLeft != 4'h0) begin
      srcByte = outSr;
    end else if (isStatusRd) begin
      srcByte = statusLive;
    end else begin
      srcByte = memArray[addrReg[7:0]];
    end
    writeOk = latchReg || volatileArm;
    wrLenOk = wrBits == 5'h8 || (wrBits == 5'h10 && cmdReg == `CMD_STATUS_WR);
    wrFirst = (wrBits == 5'h10) ? wrData[15:8] : wrData[7:0];
    nvAccept = csnRise && phaseReg == PH_WDATA && !busyReg && writeOk && wrLenOk
      && (cmdReg == `CMD_STATUS_WR || cmdReg == `CMD_STATUS_TWO_WR) && !volatileArm;
  end

  // array preload
  always_ff @(posedge clk) begin
    if (ce && memWrEn) begin
      memArray[memWrAddr] <= memWrData;
    end
  end

  // instruction, address, dummy and data phases
  always_ff @(posedge clk) begin
    if (!rstn) begin
      phaseReg <= PH_CMD;
      cmdReg <= 8'h00;
      inSr <= 8'h00;
      bitCnt <= 4'h0;
      addrReg <= 24'h000000;
      addrBytes <= 2'h0;
      dummyCnt <= 4'h0;
      wrBits <= 5'h00;
      wrData <= 16'h0000;
      outSr <= 8'h00;
      outLeft <= 4'h0;
      linkOut <= '{lanes: 4'h0, oe: 4'h0};
    end else if (ce) begin
      if (linkS2.csn) begin
        phaseReg <= PH_CMD;
        bitCnt <= 4'h0;
        addrBytes <= 2'h0;
        dummyCnt <= 4'h0;
        outLeft <= 4'h0;
        linkOut.oe <= 4'h0;
        if (!csnRise) begin
          wrBits <= 5'h00;
        end
      end else begin
        if (sckRise) begin
          bitCnt <= byteDone ? 4'h0 : cntNext;
          inSr <= inNext;
          case (phaseReg)
            PH_CMD: begin
              if (byteDone) begin
                cmdReg <= inNext;
                case (inNext)
                  `CMD_READ, `CMD_FAST_READ:
                    phaseReg <= busyReg ? PH_IGNORE : PH_ADDR;
                  `CMD_DUAL_READ:
                    phaseReg <= (busyReg || fourLaneCommandMode) ? PH_IGNORE : PH_ADDR;
                  `CMD_STATUS_ONE_RD, `CMD_STATUS_TWO_RD:
                    phaseReg <= PH_DATA;
                  `CMD_STATUS_WR, `CMD_STATUS_TWO_WR, `CMD_READ_PARAM:
                    phaseReg <= PH_WDATA;
                  `CMD_LATCH_SET, `CMD_LATCH_CLEAR, `CMD_VOLATILE_SET:
                    phaseReg <= PH_DONE;
                  default:
                    phaseReg <= PH_IGNORE;
                endcase
              end
            end
            PH_ADDR: begin
              if (byteDone) begin
                addrReg <= {addrReg[15:0], inNext};
                addrBytes <= addrBytes + 2'h1;
                if (addrBytes == 2'h2) begin
                  phaseReg <= (cmdReg == `CMD_READ) ? PH_DATA : PH_DUMMY;
                end
              end
            end
            PH_DUMMY: begin
              dummyCnt <= dummyCnt + 4'h1;
              if (dummyCnt + 4'h1 == dummyTarget) begin
                phaseReg <= PH_DATA;
              end
            end
            PH_WDATA: begin
              if (wrBits < 5'h10) begin
                wrBits <= wrBits + {1'b0, laneW};
              end else begin
                wrBits <= 5'h1f;
              end
              wrData <= fourLaneCommandMode ? {wrData[11:0], linkS2.lanes}
                : {wrData[14:0], linkS2.lanes[0]};
            end
            PH_DONE: phaseReg <= PH_IGNORE;
            default: phaseReg <= phaseReg;
          endcase
        end
        if (sckFall && phaseReg == PH_DATA) begin
          if (outLeft == 4'h0 && !isStatusRd) begin
            addrReg <= addrReg + 24'h000001;
          end
          case (outW)
            4'h4: begin
              linkOut.lanes <= srcByte[7:4];
              linkOut.oe <= 4'hf;
            end
            4'h2: begin
              linkOut.lanes <= {2'b00, srcByte[7:6]};
              linkOut.oe <= 4'h3;
            end
            default: begin
              linkOut.lanes <= {2'b00, srcByte[7], 1'b0};
              linkOut.oe <= 4'h2;
            end
          endcase
          outSr <= srcByte << outW;
          outLeft <= ((outLeft == 4'h0) ? 4'h8 : outLeft) - outW;
        end
      end
    end
  end

  // status bits, latch, busy cycle and read parameter
  always_ff @(posedge clk) begin
    if (!rstn) begin
      statusOneBits <= 6'(`STATUS_ONE_RESET >> 2);
      statusOne <= `STATUS_ONE_RESET;
      statusTwo <= `STATUS_TWO_RESET;
      busyOut <= 1'b0;
      statusTwoReg <= `STATUS_TWO_RESET;
      latchReg <= 1'b0;
      volatileArm <= 1'b0;
      busyReg <= 1'b0;
      busyTimer <= 16'h0000;
      readParam <= `READ_PARAM_RESET;
    end else if (ce) begin
      if (busyReg) begin
        busyTimer <= busyTimer - 16'h0001;
        if (busyTimer == 16'h0001) begin
          busyReg <= 1'b0;
          latchReg <= 1'b0;
        end
      end
      if (csnRise && phaseReg == PH_DONE) begin
        if (cmdReg == `CMD_LATCH_SET) begin
          latchReg <= 1'b1;
        end else if (cmdReg == `CMD_LATCH_CLEAR) begin
          latchReg <= 1'b0;
        end else if (cmdReg == `CMD_VOLATILE_SET) begin
          volatileArm <= 1'b1;
        end
      end
      if (csnRise && phaseReg == PH_WDATA && !busyReg && writeOk && wrLenOk) begin
        if (cmdReg == `CMD_STATUS_WR) begin
          statusOneBits <= (statusOneBits & ~6'(`STATUS_ONE_WR_MASK >> 2))
            | (wrFirst[7:2] & 6'(`STATUS_ONE_WR_MASK >> 2));
          if (wrBits == 5'h10) begin
            statusTwoReg <= (statusTwoReg & ~`STATUS_TWO_WR_MASK)
              | (wrData[7:0] & `STATUS_TWO_WR_MASK);
          end else begin
            statusTwoReg <= statusTwoReg & ~`STATUS_TWO_WR_MASK;
          end
        end else if (cmdReg == `CMD_STATUS_TWO_WR) begin
          statusTwoReg <= (statusTwoReg & ~`STATUS_TWO_WR_MASK)
            | (wrData[7:0] & `STATUS_TWO_WR_MASK);
        end
        if (cmdReg != `CMD_READ_PARAM) begin
          volatileArm <= 1'b0;
        end
      end
      if (csnRise && phaseReg == PH_WDATA && cmdReg == `CMD_READ_PARAM && wrBits == 5'h8) begin
        readParam <= wrData[5:4];
      end
      if (nvAccept) begin
        busyReg <= 1'b1;
        busyTimer <= 16'(`STATUS_WRITE_CYCLES);
        latchReg <= 1'b0;
      end
      statusOne <= {statusOneBits, latchReg, busyReg};
      statusTwo <= statusTwoReg;
      busyOut <= busyReg;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || !ce);

  latch_set_a: assert property (csnRise && phaseReg == PH_DONE
    && cmdReg == `CMD_LATCH_SET |=> latchReg) else $error("latch not set");
  latch_clear_a: assert property (csnRise && phaseReg == PH_DONE
    && cmdReg == `CMD_LATCH_CLEAR && !nvAccept |=> !latchReg)
    else $error("latch not cleared");
  volatile_keeps_a: assert property (csnRise && phaseReg == PH_DONE
    && cmdReg == `CMD_VOLATILE_SET && !busyReg |=> $stable(latchReg))
    else $error("volatile enable moved latch");
  busy_start_a: assert property (nvAccept |=> busyReg && !latchReg
    && busyTimer == 16'(`STATUS_WRITE_CYCLES)) else $error("busy start wrong");
  busy_end_a: assert property (busyReg && busyTimer == 16'h0001 && !csnRise
    |=> !busyReg && !latchReg) else $error("busy end wrong");
  bad_length_a: assert property (csnRise && phaseReg == PH_WDATA && !wrLenOk
    |=> $stable(statusOneBits) && $stable(statusTwoReg))
    else $error("odd length write applied");
  short_write_a: assert property (csnRise && phaseReg == PH_WDATA && !busyReg
    && writeOk && cmdReg == `CMD_STATUS_WR && wrBits == 5'h8
    |=> (statusTwoReg & `STATUS_TWO_WR_MASK) == 8'h00)
    else $error("short write kept bits");
  no_enable_a: assert property (csnRise && phaseReg == PH_WDATA && !writeOk
    && cmdReg != `CMD_READ_PARAM |=> $stable(statusOneBits) && !$rose(busyReg))
    else $error("unenabled write acted");
  busy_read_a: assert property (sckRise && phaseReg == PH_CMD && byteDone
    && busyReg && (inNext == `CMD_READ || inNext == `CMD_FAST_READ
    || inNext == `CMD_DUAL_READ) |=> phaseReg == PH_IGNORE)
    else $error("read taken while busy");
  dummy_len_a: assert property (phaseReg == PH_DUMMY && sckRise
    && dummyCnt + 4'h1 == dummyTarget |=> phaseReg == PH_DATA
    && (fourLaneCommandMode ? dummyCnt inside {4'h4, 4'h6, 4'h8} : dummyCnt == 4'h8))
    else $error("dummy count wrong");
  dual_lanes_a: assert property (sckFall && phaseReg == PH_DATA
    && cmdReg == `CMD_DUAL_READ |=> linkOut.oe == 4'h3)
    else $error("dual lanes not driven");

  write_seen_c: cover property (nvAccept);
  status_rd_c: cover property (sckFall && phaseReg == PH_DATA && isStatusRd && busyReg);
  dual_rd_c: cover property (sckFall && phaseReg == PH_DATA && cmdReg == `CMD_DUAL_READ);
endmodule // serial_flash_cmd

// file: verification/flash_host_model.sv
// host controller model that drives the flash link pins
`timescale 1ns/1ps
module flash_host_model import flash_cmd_pkg::*; (
  // clock
  input wire logic clk,
  // link pins
  input wire link_out_s linkOut,
  output link_in_s linkIn,
  // captured bytes
  output logic [7:0] rxByte,
  output logic rxValid
);
  logic csnPin = 1'b1;
  logic sckPin = 1'b0;
  logic [3:0] drv = 4'h0;
  logic [3:0] en = 4'h0;
  logic [3:0] tog = 4'h5;
  initial begin
    rxByte = 8'h00;
    rxValid = 1'b0;
  end
  // released lanes change every cycle
  always @(negedge clk) tog <= ~tog;
  assign linkIn = {csnPin, sckPin,
    (linkOut.oe & linkOut.lanes) | (~linkOut.oe & ((en & drv) | (~en & tog)))};
  task automatic open_frame();
    @(negedge clk);
    csnPin = 1'b0;
    repeat (16) @(negedge clk);
  endtask
  // chip select high ends the instruction
  task automatic close_frame();
    en = 4'h0;
    csnPin = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  // one byte over w lanes; mode 0 send, 1 capture, 2 idle clocks
  task automatic xfer(input logic [7:0] b, input int w, input int mode);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < 8 / w; k++) begin
      en = (mode == 0) ? ((w == 1) ? 4'h1 : 4'hf) : 4'h0;
      for (int j = 0; j < w; j++) drv[(w == 1) ? 0 : w - 1 - j] = b[7 - k * w - j];
      repeat (16) @(negedge clk);
      for (int j = 0; j < w; j++) r[7 - k * w - j] = linkIn.lanes[(w == 1) ? 1 : w - 1 - j];
      if (mode == 1 && k == 8 / w - 1) begin
        rxByte = r;
        rxValid = 1'b1;
      end
      sckPin = 1'b1;
      @(negedge clk);
      rxValid = 1'b0;
      repeat (15) @(negedge clk);
      sckPin = 1'b0;
    end
  endtask
endmodule // flash_host_model

// file: verification/serial_flash_cmd_tb_top.sv
// self-checking bench of the serial flash instruction front end
`timescale 1ns/1ps
`include "flash_cmd_cfg.svh"
module serial_flash_cmd_tb_top import flash_cmd_pkg::*; ;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic fourLaneCommandMode = 1'b0;
  logic memWrEn = 1'b0;
  logic [7:0] memWrAddr = 8'h00;
  logic [7:0] memWrData = 8'h00;
  link_in_s linkIn;
  link_out_s linkOut;
  logic [7:0] statusOne, statusTwo, rxByte;
  logic busyOut, rxValid;
  logic quiet = 1'b0;
  logic [7:0] mem [256];
  logic [7:0] expQ [$];
  logic [31:0] seed = 32'h23f9;
  logic [7:0] prm [4] = '{8'h00, 8'h10, 8'h20, 8'h30};
  int dum [4] = '{`QUAD_DUMMY_LOW, `QUAD_DUMMY_MID, `QUAD_DUMMY_HIGH, `QUAD_DUMMY_HIGH};
  int fails = 0;
  int checked = 0;
  int cyc;
  always #2.5 clk = ~clk;
  serial_flash_cmd uut (.clk(clk), .rstn(rstn), .ce(1'b1), .linkIn(linkIn),
    .linkOut(linkOut), .fourLaneCommandMode(fourLaneCommandMode), .memWrEn(memWrEn),
    .memWrAddr(memWrAddr), .memWrData(memWrData), .statusOne(statusOne),
    .statusTwo(statusTwo), .busyOut(busyOut));
  flash_host_model host (.clk(clk), .linkOut(linkOut), .linkIn(linkIn), .rxByte(rxByte),
    .rxValid(rxValid));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) if (rxValid) check(rxByte, expQ.pop_front());
  always @(posedge clk) if (quiet) check({4'h0, linkOut.oe}, 8'h00);
  task automatic send_frame(input logic [23:0] v, input int n);
    host.open_frame();
    for (int i = n - 1; i >= 0; i--) host.xfer(v[8 * i +: 8], fourLaneCommandMode ? 4 : 1, 0);
    host.close_frame();
  endtask
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int na, input int dm,
      input int w, input int n);
    host.open_frame();
    host.xfer(op, fourLaneCommandMode ? 4 : 1, 0);
    for (int i = na - 1; i >= 0; i--) host.xfer(a[8 * i +: 8], fourLaneCommandMode ? 4 : 1, 0);
    repeat (dm / 2) host.xfer(8'h00, 4, 2);
    repeat (n) host.xfer(8'h00, w, 1);
    host.close_frame();
  endtask
  task automatic wait_idle();
    cyc = 0;
    while (busyOut !== 1'b0 && cyc < 400) begin
      @(negedge clk);
      cyc++;
    end
    @(negedge clk);
    if (cyc >= 400) begin
      fails++;
      tally_and_finish();
    end
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    check(statusOne, `STATUS_ONE_RESET);
    check(statusTwo, `STATUS_TWO_RESET);
    for (int i = 0; i < 256; i++) begin
      seed = lfsr(seed);
      memWrEn = 1'b1;
      memWrAddr = 8'(i);
      memWrData = seed[7:0];
      mem[i] = seed[7:0];
      @(negedge clk);
    end
    memWrEn = 1'b0;
    for (int i = 0; i < 3; i++) expQ.push_back(mem[8'(8'hfe + i)]);
    rd(`CMD_READ, 24'h5aa0fe, 3, 0, 1, 3);
    for (int i = 0; i < 2; i++) expQ.push_back(mem[8'h10 + i]);
    rd(`CMD_FAST_READ, 24'h000010, 3, `SPI_DUMMY_CLOCKS, 1, 2);
    for (int i = 0; i < 2; i++) expQ.push_back(mem[8'h80 + i]);
    rd(`CMD_DUAL_READ, 24'h000080, 3, 8, 2, 2);
    send_frame({`CMD_STATUS_WR, 16'hffff}, 3);
    check(statusOne, 8'h00);
    send_frame(`CMD_LATCH_SET, 1);
    check(statusOne, 8'h02);
    send_frame(`CMD_LATCH_CLEAR, 1);
    check(statusOne, 8'h00);
    send_frame(`CMD_LATCH_SET, 1);
    send_frame({`CMD_STATUS_WR, 16'hffff}, 3);
    check({6'h00, statusOne[1:0]}, 8'h01);
    check({7'h00, busyOut}, 8'h01);
    wait_idle();
    check(8'(cyc > `STATUS_WRITE_CYCLES - 16 && cyc <= `STATUS_WRITE_CYCLES), 8'h01);
    check(statusOne, 8'hff & `STATUS_ONE_WR_MASK);
    check(statusTwo, 8'hff & `STATUS_TWO_WR_MASK);
    send_frame(`CMD_LATCH_SET, 1);
    send_frame({`CMD_STATUS_TWO_WR, 16'h0000}, 3);
    check(statusTwo, 8'hff & `STATUS_TWO_WR_MASK);
    check({7'h00, busyOut}, 8'h00);
    send_frame(`CMD_LATCH_SET, 1);
    send_frame({`CMD_STATUS_WR, 8'h84}, 2);
    wait_idle();
    check(statusOne, 8'h84);
    check(statusTwo, 8'h00);
    expQ.push_back(8'h84);
    expQ.push_back(8'h84);
    rd(`CMD_STATUS_ONE_RD, 24'h0, 0, 0, 1, 2);
    expQ.push_back(8'h00);
    rd(`CMD_STATUS_TWO_RD, 24'h0, 0, 0, 1, 1);
    // no write latch set between these two frames
    send_frame(`CMD_VOLATILE_SET, 1);
    send_frame({`CMD_STATUS_TWO_WR, 8'hbe}, 2);
    check(statusTwo, 8'h02);
    check(statusOne, 8'h84);
    fourLaneCommandMode = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (i > 0) send_frame({`CMD_READ_PARAM, prm[i]}, 2);
      expQ.push_back(mem[i]);
      rd(`CMD_FAST_READ, 24'(i), 3, dum[i], 4, 1);
    end
    send_frame(`CMD_LATCH_SET, 1);
    send_frame({`CMD_STATUS_WR, 16'h8402}, 3);
    expQ.push_back(8'h85);
    rd(`CMD_STATUS_ONE_RD, 24'h0, 0, 0, 4, 1);
    wait_idle();
    send_frame(`CMD_LATCH_SET, 1);
    send_frame({`CMD_STATUS_WR, 16'h8402}, 3);
    quiet = 1'b1;
    rd(`CMD_FAST_READ, 24'h0, 3, 12, 4, 0);
    quiet = 1'b0;
    wait_idle();
    check(statusOne, 8'h84);
    tally_and_finish();
  end
endmodule // serial_flash_cmd_tb_top
